/* src/kps_defs.svh */
// Constants for the knock processor serial configuration block.
`ifndef KPS_DEFS_SVH
`define KPS_DEFS_SVH
`define KPS_WORD_BITS 8
`define KPS_CNT_W 4
`define KPS_ADDR2_BANDPASS 2'b00
`define KPS_ADDR2_PRESC 2'b01
`define KPS_ADDR2_GAIN 2'b10
`define KPS_ADDR3_TC 3'b110
`define KPS_ADDR3_TEST 3'b111
`define KPS_RST_BANDPASS 6'h00
`define KPS_RST_GAIN 6'h00
`define KPS_RST_TC 5'h00
`define KPS_RST_TEST 5'h00
`define KPS_RST_PRESC 6'h01
`define KPS_PRESC_TRI_BIT 0
`define KPS_PRESC_SPARE_BIT 5
`define KPS_CHAN_SEL_BIT 0
`define KPS_PRESC_MAX_CODE 4'h8
`define KPS_INT_RESET_US 20
`define KPS_CLK_MHZ 25
`define KPS_INT_RESET_CYC (`KPS_INT_RESET_US * `KPS_CLK_MHZ)
`endif

/* src/kps_pkg.sv */
// Types shared by the knock processor serial configuration block.
package kps_pkg;
  typedef enum logic [1:0] {
    KPS_IDLE = 2'b00,
    KPS_SHIFT = 2'b01,
    KPS_BAD = 2'b10
  } kps_frame_e;
  typedef enum logic [1:0] {
    KPS_HOLD = 2'b00,
    KPS_RESET_INT = 2'b01,
    KPS_INTEGRATE = 2'b10
  } kps_integ_e;
endpackage

/* src/kps_sync.sv */
// Two flip-flop synchroniser for one pin level.
`timescale 1ns/10ps
module kps_sync (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_rst_val,
  // Asynchronous level and its synchronised copy.
  input wire logic i_async,
  output logic o_sync
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  // The first stage feeds only the second stage.
  always_comb begin
    meta_d = i_async;
    sync_d = meta_q;
    if (!i_resetn) begin
      meta_d = i_rst_val;
      sync_d = i_rst_val;
    end
  end

  // Register both stages.
  always_ff @(posedge i_sys_clk) begin
    meta_q <= meta_d;
    sync_q <= sync_d;
  end

  assign o_sync = sync_q;
endmodule // kps_sync

/* src/kps_divider.sv */
// Oscillator divider producing the switched-capacitor rate enable.
`timescale 1ns/10ps
`include "kps_defs.svh"
module kps_divider (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // Divider selection.
  input wire logic [3:0] i_presc_sel,
  // Rate enable.
  output logic o_tick
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic tick_q;
  logic tick_d;
  logic [7:0] ratio;

  // Division ratio per selected input clock, for a 200 kHz rate.
  always_comb begin
    unique case (i_presc_sel)
      4'h0: ratio = 8'h14;
      4'h1: ratio = 8'h19;
      4'h2: ratio = 8'h1E;
      4'h3: ratio = 8'h28;
      4'h4: ratio = 8'h32;
      4'h5: ratio = 8'h3C;
      4'h6: ratio = 8'h50;
      4'h7: ratio = 8'h64;
      4'h8: ratio = 8'h78;
      default: ratio = 8'h78;
    endcase
  end

  // Count down and pulse on terminal count.
  always_comb begin
    cnt_d = cnt_q - 8'h01;
    tick_d = 1'b0;
    if (cnt_q <= 8'h01) begin
      cnt_d = ratio;
      tick_d = 1'b1;
    end
    if (!i_resetn) begin
      cnt_d = 8'h14;
      tick_d = 1'b0;
    end
  end

  // Register the divider state.
  always_ff @(posedge i_sys_clk) begin
    cnt_q <= cnt_d;
    tick_q <= tick_d;
  end

  assign o_tick = tick_q;
endmodule // kps_divider

/* src/kps_config.sv */
// Serial configuration receiver and register decode for a knock processor.
`timescale 1ns/10ps
`include "kps_defs.svh"
module kps_config
  import kps_pkg::*;
(
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // Serial pins.
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_si,
  // Control pins.
  input wire logic i_int_hold,
  input wire logic i_test_n,
  // Serial output pin.
  output logic o_so,
  output logic o_so_oe,
  // Analog stage settings.
  output logic [5:0] o_bandpass_code,
  output logic [5:0] o_gain_code,
  output logic [4:0] o_tc_code,
  output logic o_chan_sel,
  output logic [3:0] o_diag_mode,
  output logic [3:0] o_presc_sel,
  output logic o_int_reset,
  output logic o_integrate,
  output logic o_sc_tick
);
  logic cs_n_s;
  logic sck_s;
  logic si_s;
  logic ih_s;
  logic test_n_s;
  logic tick;

  kps_sync u_sync_cs (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .i_rst_val(1'b1), .i_async(i_cs_n), .o_sync(cs_n_s));
  kps_sync u_sync_sck (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .i_rst_val(1'b0), .i_async(i_sck), .o_sync(sck_s));
  kps_sync u_sync_si (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .i_rst_val(1'b0), .i_async(i_si), .o_sync(si_s));
  kps_sync u_sync_ih (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .i_rst_val(1'b0), .i_async(i_int_hold), .o_sync(ih_s));
  kps_sync u_sync_test (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .i_rst_val(1'b1), .i_async(i_test_n), .o_sync(test_n_s));

  // Edge history of the synchronised pins.
  logic cs_prev_q;
  logic cs_prev_d;
  logic sck_prev_q;
  logic sck_prev_d;
  logic ih_prev_q;
  logic ih_prev_d;
  logic cs_fall;
  logic cs_rise;
  logic sck_fall;
  logic ih_rise;

  // Edge detection on the second synchroniser stage only.
  always_comb begin
    cs_prev_d = i_resetn ? cs_n_s : 1'b1;
    sck_prev_d = i_resetn ? sck_s : 1'b0;
    ih_prev_d = i_resetn ? ih_s : 1'b0;
  end

  always_ff @(posedge i_sys_clk) begin
    cs_prev_q <= cs_prev_d;
    sck_prev_q <= sck_prev_d;
    ih_prev_q <= ih_prev_d;
  end

  assign cs_fall = cs_prev_q && !cs_n_s;
  assign cs_rise = !cs_prev_q && cs_n_s;
  assign sck_fall = sck_prev_q && !sck_s;
  assign ih_rise = !ih_prev_q && ih_s;

  // Frame reception state.
  kps_frame_e frame_q;
  kps_frame_e frame_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [3:0] bits_q;
  logic [3:0] bits_d;
  logic accept;

  // Shift in on SCK falling while selected; flag malformed frames.
  always_comb begin
    frame_d = frame_q;
    shift_d = shift_q;
    bits_d = bits_q;
    accept = 1'b0;
    unique case (frame_q)
      KPS_IDLE: begin
        if (cs_fall) begin
          bits_d = 4'h0;
          frame_d = sck_s ? KPS_BAD : KPS_SHIFT;
        end
      end
      KPS_SHIFT: begin
        if (cs_rise) begin
          frame_d = KPS_IDLE;
          // Eight pulses, SCK ending low.
          accept = (bits_q == 4'h8) && !sck_s;
        end else if (sck_fall) begin
          shift_d = {shift_q[6:0], si_s};
          if (bits_q == 4'h8) begin
            frame_d = KPS_BAD;
          end else begin
            bits_d = bits_q + 4'h1;
          end
        end
      end
      KPS_BAD: begin
        if (cs_rise) begin
          frame_d = KPS_IDLE;
        end
      end
      default: frame_d = KPS_IDLE;
    endcase
    if (!i_resetn) begin
      frame_d = KPS_IDLE;
      shift_d = 8'h00;
      bits_d = 4'h0;
      accept = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    frame_q <= frame_d;
    shift_q <= shift_d;
    bits_q <= bits_d;
  end

  // Configuration registers, accepted in either integrate or hold mode.
  logic [5:0] bandpass_center_code_q;
  logic [5:0] bandpass_center_code_d;
  logic [5:0] gain_code_q;
  logic [5:0] gain_code_d;
  logic [4:0] integrator_tc_code_q;
  logic [4:0] integrator_tc_code_d;
  logic [4:0] test_channel_select_q;
  logic [4:0] test_channel_select_d;
  logic [5:0] prescaler_out_control_q;
  logic [5:0] prescaler_out_control_d;

  // Address decode of an accepted word.
  always_comb begin
    bandpass_center_code_d = bandpass_center_code_q;
    gain_code_d = gain_code_q;
    integrator_tc_code_d = integrator_tc_code_q;
    test_channel_select_d = test_channel_select_q;
    prescaler_out_control_d = prescaler_out_control_q;
    if (accept) begin
      if (shift_q[7:6] == `KPS_ADDR2_BANDPASS) begin
        bandpass_center_code_d = shift_q[5:0];
      end else if (shift_q[7:6] == `KPS_ADDR2_GAIN) begin
        gain_code_d = shift_q[5:0];
      end else if (shift_q[7:6] == `KPS_ADDR2_PRESC) begin
        prescaler_out_control_d = shift_q[5:0];
      end else if (shift_q[7:5] == `KPS_ADDR3_TC) begin
        integrator_tc_code_d = shift_q[4:0];
      end else begin
        test_channel_select_d = shift_q[4:0];
      end
    end
    if (!i_resetn) begin
      bandpass_center_code_d = `KPS_RST_BANDPASS;
      gain_code_d = `KPS_RST_GAIN;
      integrator_tc_code_d = `KPS_RST_TC;
      test_channel_select_d = `KPS_RST_TEST;
      prescaler_out_control_d = `KPS_RST_PRESC;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    bandpass_center_code_q <= bandpass_center_code_d;
    gain_code_q <= gain_code_d;
    integrator_tc_code_q <= integrator_tc_code_d;
    test_channel_select_q <= test_channel_select_d;
    prescaler_out_control_q <= prescaler_out_control_d;
  end

  // Divider uses only prescaler bits 4 to 1; spare bit 5 ignored.
  logic [3:0] presc_sel;
  assign presc_sel = prescaler_out_control_q[4:1];

  kps_divider u_div (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_presc_sel(presc_sel),
    .o_tick(tick)
  );

  // Integrate/hold sequencing with integrator reset window.
  kps_integ_e integ_q;
  kps_integ_e integ_d;
  logic [9:0] icnt_q;
  logic [9:0] icnt_d;

  always_comb begin
    integ_d = integ_q;
    icnt_d = icnt_q;
    unique case (integ_q)
      KPS_HOLD: begin
        if (ih_rise) begin
          integ_d = KPS_RESET_INT;
          icnt_d = 10'(`KPS_INT_RESET_CYC - 1);
        end
      end
      KPS_RESET_INT: begin
        if (!ih_s) begin
          integ_d = KPS_HOLD;
        end else if (icnt_q == 10'h000) begin
          integ_d = KPS_INTEGRATE;
        end else begin
          icnt_d = icnt_q - 10'h001;
        end
      end
      KPS_INTEGRATE: begin
        if (!ih_s) begin
          integ_d = KPS_HOLD;
        end
      end
      default: integ_d = KPS_HOLD;
    endcase
    if (!i_resetn) begin
      integ_d = KPS_HOLD;
      icnt_d = 10'h000;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    integ_q <= integ_d;
    icnt_q <= icnt_d;
  end

  // Output registers driven straight from flip-flops.
  logic so_q;
  logic so_d;
  logic so_oe_q;
  logic so_oe_d;
  logic [3:0] diag_q;
  logic [3:0] diag_d;
  logic int_reset_q;
  logic int_reset_d;
  logic integrate_q;
  logic integrate_d;
  logic tick_q;
  logic tick_d;
  logic [3:0] presc_q;
  logic [3:0] presc_d;

  // Serial output echoes the synchronised SI pin in diagnostics, else low.
  always_comb begin
    so_oe_d = !prescaler_out_control_q[`KPS_PRESC_TRI_BIT];
    diag_d = 4'h0;
    so_d = 1'b0;
    if (!test_n_s) begin
      diag_d = test_channel_select_q[4:1];
      so_d = si_s;
    end
    int_reset_d = (integ_q == KPS_RESET_INT);
    integrate_d = (integ_q == KPS_INTEGRATE);
    tick_d = tick;
    presc_d = presc_sel;
    if (!i_resetn) begin
      so_oe_d = 1'b0;
      diag_d = 4'h0;
      so_d = 1'b0;
      int_reset_d = 1'b0;
      integrate_d = 1'b0;
      tick_d = 1'b0;
      presc_d = 4'h0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    so_q <= so_d;
    so_oe_q <= so_oe_d;
    diag_q <= diag_d;
    int_reset_q <= int_reset_d;
    integrate_q <= integrate_d;
    tick_q <= tick_d;
    presc_q <= presc_d;
  end

  assign o_so = so_q;
  assign o_so_oe = so_oe_q;
  assign o_bandpass_code = bandpass_center_code_q;
  assign o_gain_code = gain_code_q;
  assign o_tc_code = integrator_tc_code_q;
  assign o_chan_sel = test_channel_select_q[`KPS_CHAN_SEL_BIT];
  assign o_diag_mode = diag_q;
  assign o_presc_sel = presc_q;
  assign o_int_reset = int_reset_q;
  assign o_integrate = integrate_q;
  assign o_sc_tick = tick_q;
endmodule // kps_config

/* tb/kps_config_checker.sv */
// Assertion checker bound to the serial configuration block.
`timescale 1ns/10ps
module kps_config_checker (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // Pins.
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_si,
  input wire logic i_int_hold,
  input wire logic i_test_n,
  // Outputs.
  input wire logic o_so,
  input wire logic o_so_oe,
  input wire logic [5:0] o_bandpass_code,
  input wire logic [5:0] o_gain_code,
  input wire logic [4:0] o_tc_code,
  input wire logic o_chan_sel,
  input wire logic [3:0] o_diag_mode,
  input wire logic [3:0] o_presc_sel,
  input wire logic o_int_reset,
  input wire logic o_integrate,
  input wire logic o_sc_tick
);
  logic cs_q;
  logic [3:0] since_q;
  logic [9:0] rlen_q;
  // Counts cycles since select rose and the length of the reset window.
  always_ff @(posedge i_sys_clk) begin
    cs_q <= i_cs_n;
    if (!i_resetn) since_q <= 4'hF;
    else if (i_cs_n && !cs_q) since_q <= 4'h0;
    else if (since_q != 4'hF) since_q <= since_q + 4'h1;
    rlen_q <= o_int_reset ? rlen_q + 10'h001 : 10'h000;
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  bp_load_a: assert property (
    $changed(o_bandpass_code) |-> since_q < 4'hA)
    else $error("band-pass code moved outside a load");
  gain_load_a: assert property (
    $changed(o_gain_code) |-> since_q < 4'hA)
    else $error("gain code moved outside a load");
  tc_load_a: assert property (
    $changed(o_tc_code) |-> since_q < 4'hA)
    else $error("time constant moved outside a load");
  chan_load_a: assert property (
    $changed(o_chan_sel) |-> since_q < 4'hA)
    else $error("channel select moved outside a load");
  presc_load_a: assert property (
    $changed({o_presc_sel, o_so_oe}) |-> since_q < 4'hA)
    else $error("prescaler or enable moved outside a load");
  diag_off_a: assert property (
    i_test_n [*6] |-> o_diag_mode == 4'h0 && !o_so)
    else $error("diagnostic outputs active in run mode");
  so_echo_a: assert property (
    !i_test_n [*6] |-> o_so == $past(i_si, 3))
    else $error("serial output does not echo the input pin");
  int_start_a: assert property (
    $rose(i_int_hold) |-> ##[1:6] o_int_reset)
    else $error("integrator reset did not start");
  int_len_a: assert property (
    $fell(o_int_reset) && i_int_hold |-> rlen_q == 10'h1F4 && o_integrate)
    else $error("integrator reset window has wrong length");
  hold_stop_a: assert property (
    !i_int_hold [*6] |-> !o_integrate && !o_int_reset)
    else $error("integration active in hold");
  int_excl_a: assert property (!(o_int_reset && o_integrate))
    else $error("reset and integrate both high");
  tick_pulse_a: assert property (o_sc_tick |=> !o_sc_tick)
    else $error("rate tick longer than one cycle");
endmodule // kps_config_checker
bind kps_config kps_config_checker i_kps_config_checker (
  .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_cs_n(i_cs_n),
  .i_sck(i_sck), .i_si(i_si), .i_int_hold(i_int_hold),
  .i_test_n(i_test_n), .o_so(o_so), .o_so_oe(o_so_oe),
  .o_bandpass_code(o_bandpass_code), .o_gain_code(o_gain_code),
  .o_tc_code(o_tc_code), .o_chan_sel(o_chan_sel),
  .o_diag_mode(o_diag_mode), .o_presc_sel(o_presc_sel),
  .o_int_reset(o_int_reset), .o_integrate(o_integrate),
  .o_sc_tick(o_sc_tick)
);

/* tb/kps_host.sv */
// Host-side serial master model for the configuration port.
`timescale 1ns/10ps
module kps_host (
  // Clock.
  input wire logic i_sys_clk,
  // Serial pins toward the device.
  output logic o_cs_n,
  output logic o_sck,
  output logic o_si
);
  // Idle bus: select high, clock low.
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_si = 1'b0;
  end
  // Waits a number of clock edges.
  task automatic edges(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask
  // Sends n clock pulses of a word; sck_hi leaves the clock high at select.
  task automatic xfer(input logic [7:0] w, input int n, input logic sck_hi);
    logic [7:0] sh;
    sh = w;
    @(posedge i_sys_clk);
    o_sck <= sck_hi;
    edges(4);
    o_cs_n <= 1'b0;
    edges(4);
    for (int i = 0; i < n; i++) begin
      o_si <= sh[7];
      sh = {sh[6:0], ~sh[0]};
      o_sck <= 1'b1;
      edges(4);
      o_sck <= 1'b0;
      edges(4);
    end
    o_cs_n <= 1'b1;
    o_si <= ~o_si;
    edges(10);
  endtask
endmodule // kps_host

/* tb/kps_config_tb.sv */
// Self-checking bench for the serial configuration block.
`timescale 1ns/10ps
module kps_config_tb;
  logic i_sys_clk, i_resetn, i_int_hold, i_test_n, cs_n, sck, si;
  logic o_so, o_so_oe, o_chan_sel, o_int_reset, o_integrate, o_sc_tick;
  logic [5:0] o_bandpass_code, o_gain_code;
  logic [4:0] o_tc_code;
  logic [3:0] o_diag_mode, o_presc_sel;
  logic [7:0] div [9] = '{8'h14, 8'h19, 8'h1E, 8'h28, 8'h32, 8'h3C,
    8'h50, 8'h64, 8'h78};
  int n_fail = 0;
  int tests_run = 0;
  kps_host i_kps_host (.i_sys_clk(i_sys_clk), .o_cs_n(cs_n), .o_sck(sck),
    .o_si(si));
  kps_config i_kps_config (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .i_cs_n(cs_n), .i_sck(sck), .i_si(si), .i_int_hold(i_int_hold),
    .i_test_n(i_test_n), .o_so(o_so), .o_so_oe(o_so_oe),
    .o_bandpass_code(o_bandpass_code), .o_gain_code(o_gain_code),
    .o_tc_code(o_tc_code), .o_chan_sel(o_chan_sel),
    .o_diag_mode(o_diag_mode), .o_presc_sel(o_presc_sel),
    .o_int_reset(o_int_reset), .o_integrate(o_integrate),
    .o_sc_tick(o_sc_tick));
  // Clock at 25 MHz.
  always #20 i_sys_clk = ~i_sys_clk;
  // Compares one value and counts the outcome.
  task automatic chk(input string nm, input logic [7:0] seen,
    input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Sends a well-formed word.
  task automatic wr(input logic [7:0] w);
    i_kps_host.xfer(w, 8, 1'b0);
  endtask
  // Waits for the next rate tick, counting cycles, bounded.
  task automatic tick_gap(output int n);
    n = 0;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (o_sc_tick !== 1'b1 && n < 300);
  endtask
  // Checks the values held after reset.
  task automatic t_reset;
    chk("bandpass", 8'(o_bandpass_code), 8'h00);
    chk("gain", 8'(o_gain_code), 8'h00);
    chk("tc", 8'(o_tc_code), 8'h00);
    chk("chan", 8'(o_chan_sel), 8'h00);
    chk("presc", 8'(o_presc_sel), 8'h00);
    chk("so_oe", 8'(o_so_oe), 8'h00);
    chk("integrate", 8'(o_integrate), 8'h00);
  endtask
  // Loads every kind of word with the test pin low.
  task automatic t_words;
    i_test_n <= 1'b0;
    wr(8'h0A);
    chk("bandpass", 8'(o_bandpass_code), 8'h0A);
    chk("gain", 8'(o_gain_code), 8'h00);
    chk("so", 8'(o_so), 8'h01);
    wr(8'h94);
    chk("gain", 8'(o_gain_code), 8'h14);
    wr(8'hC3);
    chk("tc", 8'(o_tc_code), 8'h03);
    wr(8'hFB);
    chk("chan", 8'(o_chan_sel), 8'h01);
    chk("diag", 8'(o_diag_mode), 8'h0D);
    wr(8'h70);
    chk("presc", 8'(o_presc_sel), 8'h08);
    chk("so_oe", 8'(o_so_oe), 8'h01);
    wr(8'h40);
    chk("presc", 8'(o_presc_sel), 8'h00);
    wr(8'h41);
    chk("so_oe", 8'(o_so_oe), 8'h00);
    wr(8'hFA);
    chk("chan", 8'(o_chan_sel), 8'h00);
    chk("bandpass", 8'(o_bandpass_code), 8'h0A);
    i_test_n <= 1'b1;
    repeat (8) @(posedge i_sys_clk);
    chk("diag", 8'(o_diag_mode), 8'h00);
    chk("so", 8'(o_so), 8'h00);
  endtask
  // Malformed frames are dropped; a clean one then loads.
  task automatic t_refuse;
    i_kps_host.xfer(8'h2A, 7, 1'b0);
    chk("bandpass", 8'(o_bandpass_code), 8'h0A);
    i_kps_host.xfer(8'h2A, 9, 1'b0);
    chk("bandpass", 8'(o_bandpass_code), 8'h0A);
    chk("presc", 8'(o_presc_sel), 8'h00);
    i_kps_host.xfer(8'h2A, 8, 1'b1);
    chk("bandpass", 8'(o_bandpass_code), 8'h0A);
    wr(8'h2A);
    chk("bandpass", 8'(o_bandpass_code), 8'h2A);
  endtask
  // Measures the tick period for prescaler codes 0 to 8.
  task automatic t_rates;
    int n;
    for (int c = 0; c < 9; c++) begin
      wr({3'b010, c[3:0], 1'b1});
      tick_gap(n);
      tick_gap(n);
      tick_gap(n);
      chk("tick_gap", n[7:0], div[c]);
    end
  endtask
  // Integrate cycle with a load while integrating.
  task automatic t_integ;
    i_int_hold <= 1'b1;
    repeat (8) @(posedge i_sys_clk);
    chk("int_reset", 8'(o_int_reset), 8'h01);
    chk("integrate", 8'(o_integrate), 8'h00);
    repeat (500) @(posedge i_sys_clk);
    chk("int_reset", 8'(o_int_reset), 8'h00);
    chk("integrate", 8'(o_integrate), 8'h01);
    wr(8'h9F);
    chk("gain", 8'(o_gain_code), 8'h1F);
    i_int_hold <= 1'b0;
    repeat (8) @(posedge i_sys_clk);
    chk("integrate", 8'(o_integrate), 8'h00);
    chk("int_reset", 8'(o_int_reset), 8'h00);
  endtask
  // Pulses reset for four cycles.
  task automatic do_reset;
    i_resetn <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
  endtask
  // Prints the verdict and ends the run.
  task automatic finish_test;
    if (n_fail == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    i_sys_clk = 1'b0;
    i_resetn = 1'b0;
    i_int_hold = 1'b0;
    i_test_n = 1'b1;
    do_reset;
    t_reset;
    t_words;
    t_refuse;
    t_rates;
    t_integ;
    do_reset;
    t_reset;
    finish_test;
  end
  // Watchdog against a hang.
  initial begin
    #(40000 * 40);
    n_fail++;
    finish_test;
  end
endmodule // kps_config_tb
